// ---- logic/sync_memory_mode_setup_regs.vh ----
// What this block does
// RL1 - In mode-set access, the next read's address drives the memory address pins.
// RL2 - Software puts burst length in command bits two to zero: four or eight.
// RL3 - Command bit three picks sequential or interleaved bursts.
// RL4 - Command bits six to four carry column latency, two or three cycles.
// RL5 - Software keeps operating-mode and reserved command bits at zero.
// RL6 - Command bit nine forces single-word write bursts; not for ROM.
// RL7 - ROM burst length sits in bits one to zero; row and column latency follow.
// RL8 - On a 32-bit bus, address bits 22 to 10 go to pins 12 to 0.
// RL9 - On a 16-bit bus the command mapping shifts down by one bit.
// RL10 - On a 32-bit bus software uses the documented mode-set read addresses.
// RL11 - On a 16-bit bus software uses the documented mode-set read addresses.
// RL12 - Standby entry: precharge, no-ops, clock enable low, auto refresh, self refresh.
// RL13 - Standby exit: settle, clock enable high, ten no-ops, auto refresh, leave.
// RL14 - Command load drives read address as value and data pins as flash command.
// RL15 - Auto refresh selects no domain when the domain last decoded from read_addr has single write burst set, else all four.
// RL16 - Memory space splits into four domains of 256 Mbytes each.
// RL17 - Address patterns 1100, 1101, 1110 select domains zero, one, two.
// RL18 - Domain three answers 0000 with boot option one, else 1111.
// RL19 - Initialize with mode-set and no command load issues continuous no-ops.
// RL20 - Initialize alone issues precharge-all commands.
// RL21 - Each domain has its own configuration choosing DRAM, ROM or flash.
// RL22 - A read during mode-set or command load makes one command cycle.
`ifndef SYNC_MEMORY_MODE_SETUP_REGS_VH
`define SYNC_MEMORY_MODE_SETUP_REGS_VH
`define CMD_NOP        3'h0
`define CMD_PRECHARGE  3'h1
`define CMD_MODE_SET   3'h2
`define CMD_LOAD       3'h3
`define CMD_REFRESH    3'h4
`define CMD_SELF_ENTER 3'h5
`define CMD_SELF_EXIT  3'h6
`define CMD_READ       3'h7
`define TYPE_DRAM      2'h0
`define TYPE_ROM       2'h1
`define TYPE_FLASH     2'h2
`define SEL_DOMAIN0    4'hc
`define SEL_DOMAIN1    4'hd
`define SEL_DOMAIN2    4'he
`define SEL_D3_BOOT1   4'h0
`define SEL_D3_BOOT0   4'hf
`define WIDE_LOW_BIT   10
`define NARROW_LOW_BIT 9
`define EXIT_NOP_COUNT 4'ha
`define SETTLE_NS      1000
`define MCLK_NS        20
`define SETTLE_CYCLES  ((`SETTLE_NS + `MCLK_NS - 1) / `MCLK_NS)
`define RESET_CFG      4'h0
`endif

// ---- logic/domain_config_store.v ----
`timescale 1ns/100ps
`default_nettype none
// Holds one configuration word per domain; read data come from a register.
module domain_config_store #(
  parameter WIDTH = 4,
  parameter DEPTH = 4
) (
  input  wire                     mclk,
  input  wire                     reset_n,
  input  wire                     write_en,
  input  wire [1:0]               write_index,
  input  wire [WIDTH-1:0]         write_data,
  input  wire [1:0]               read_index,
  output reg  [WIDTH-1:0]         read_data
);
  reg [WIDTH-1:0] cells [0:DEPTH-1];
  integer i;

  // RL21 per-domain config.
  always @(posedge mclk) begin
    if (!reset_n) begin
      for (i = 0; i < DEPTH; i = i + 1) begin
        cells[i] <= {WIDTH{1'b0}};
      end
      read_data <= {WIDTH{1'b0}};
    end else begin
      if (write_en) begin
        cells[write_index] <= write_data;
      end
      read_data <= cells[read_index];
    end
  end
endmodule // domain_config_store
`default_nettype wire

// ---- logic/sync_memory_mode_setup.v ----
`timescale 1ns/100ps
`default_nettype none
`include "sync_memory_mode_setup_regs.vh"
// Config word per domain: [1:0] device type, [2] single_write_burst, [3] narrow bus.
module sync_memory_mode_setup #(
  parameter SETTLE_COUNT = `SETTLE_CYCLES
) (
  input  wire        mclk,
  input  wire        reset_n,
  input  wire        init_bit,
  input  wire        mode_set_access,
  input  wire        load_command_access,
  input  wire        cfg_write,
  input  wire [1:0]  cfg_index,
  input  wire [3:0]  cfg_data,
  input  wire        boot_option_pin,
  input  wire        read_req,
  input  wire [31:0] read_addr,
  input  wire [15:0] flash_command,
  input  wire        standby_req,
  input  wire        wake_req,
  input  wire        link_clock,
  output wire        read_ack,
  output reg  [12:0] mem_addr,
  output reg  [15:0] mem_data_out,
  output reg         mem_data_oe,
  output reg  [2:0]  mem_command,
  output reg  [3:0]  domain_chip_select_n,
  output reg         memory_clock_enable_out,
  output reg         in_self_refresh,
  output reg         cpu_stop_ok,
  output reg         burst_order_field,
  output reg         single_write_burst,
  output reg  [1:0]  device_type
);
  localparam ST_RUN     = 4'h0;
  localparam ST_PRE     = 4'h1;
  localparam ST_NOP     = 4'h2;
  localparam ST_CKE_LO  = 4'h3;
  localparam ST_AREF    = 4'h4;
  localparam ST_SELF    = 4'h5;
  localparam ST_SETTLE  = 4'h6;
  localparam ST_CKE_HI  = 4'h7;
  localparam ST_NOPS    = 4'h8;
  localparam ST_AREF2   = 4'h9;
  localparam ST_LEAVE   = 4'ha;

  reg        boot_sync1;
  reg        boot_sync2;
  reg        boot_option_latch;
  reg        boot_taken;
  reg        link_sync1;
  reg        link_sync2;
  reg        link_last;
  reg [3:0]  state;
  reg [15:0] count;
  reg [1:0]  sel_index;
  wire [3:0] cfg_word;

  // Decodes address bits 31 to 28 into a domain index and a hit flag.
  function [2:0] decode_domain;
    input [3:0] top;
    input       boot;
    begin
      // RL17 domains zero to two.
      if (top == `SEL_DOMAIN0) decode_domain = 3'h4;
      else if (top == `SEL_DOMAIN1) decode_domain = 3'h5;
      else if (top == `SEL_DOMAIN2) decode_domain = 3'h6;
      // RL18 domain three boot choice.
      else if (top == (boot ? `SEL_D3_BOOT1 : `SEL_D3_BOOT0)) decode_domain = 3'h7;
      else decode_domain = 3'h0;
    end
  endfunction

  wire [2:0] hit = decode_domain(read_addr[31:28], boot_option_latch);
  wire       link_rise = link_sync2 & ~link_last;

  domain_config_store #(
    .WIDTH (4),
    .DEPTH (4)
  ) store (
    .mclk        (mclk),
    .reset_n     (reset_n),
    .write_en    (cfg_write),
    .write_index (cfg_index),
    .write_data  (cfg_data),
    .read_index  (sel_index),
    .read_data   (cfg_word)
  );

  // RL22 one command per read.
  assign read_ack = read_req & (state == ST_RUN) & link_rise;

  // Boot option synchroniser runs through reset so the latch sees the settled pin.
  always @(posedge mclk) begin
    boot_sync1 <= boot_option_pin;
    boot_sync2 <= boot_sync1;
  end

  always @(posedge mclk) begin
    if (!reset_n) begin
      boot_option_latch <= 1'b0;
      boot_taken <= 1'b0;
      link_sync1 <= 1'b0;
      link_sync2 <= 1'b0;
      link_last <= 1'b0;
      state <= ST_RUN;
      count <= 16'h0000;
      sel_index <= 2'h0;
      mem_addr <= 13'h0000;
      mem_data_out <= 16'h0000;
      mem_data_oe <= 1'b0;
      mem_command <= `CMD_NOP;
      domain_chip_select_n <= 4'hf;
      memory_clock_enable_out <= 1'b1;
      in_self_refresh <= 1'b0;
      cpu_stop_ok <= 1'b0;
      burst_order_field <= 1'b0;
      single_write_burst <= 1'b0;
      device_type <= `TYPE_DRAM;
    end else begin
      link_sync1 <= link_clock;
      link_sync2 <= link_sync1;
      link_last <= link_sync2;
      // RL18 boot option latched once.
      if (!boot_taken) begin
        boot_taken <= 1'b1;
        boot_option_latch <= boot_sync2;
      end
      if (hit[2]) sel_index <= hit[1:0];
      single_write_burst <= cfg_word[2];
      device_type <= cfg_word[1:0];
      if (link_rise) begin
        mem_command <= `CMD_NOP;
        mem_data_oe <= 1'b0;
        domain_chip_select_n <= 4'hf;
        case (state)
          ST_RUN: begin
            if (standby_req) begin
              // RL12 precharge first.
              state <= ST_PRE;
            end else if (init_bit) begin
              domain_chip_select_n <= 4'h0;
              // RL19 continuous no-ops; RL20 precharge all.
              mem_command <= mode_set_access ? `CMD_NOP : `CMD_PRECHARGE;
            end else if (read_req && hit[2]) begin
              // RL16 one select per 256 Mbyte domain.
              domain_chip_select_n <= ~(4'h1 << hit[1:0]);
              // RL8 wide map; RL9 narrow map shifted.
              mem_addr <= cfg_word[3] ? read_addr[`NARROW_LOW_BIT+12:`NARROW_LOW_BIT]
                                      : read_addr[`WIDE_LOW_BIT+12:`WIDE_LOW_BIT];
              // RL3 burst order from command bit three; RL6 bit nine rides along.
              burst_order_field <= cfg_word[3] ? read_addr[`NARROW_LOW_BIT+3]
                                               : read_addr[`WIDE_LOW_BIT+3];
              if (load_command_access) begin
                // RL14 flash command on data pins.
                mem_command <= `CMD_LOAD;
                mem_data_out <= flash_command;
                mem_data_oe <= 1'b1;
              end else if (mode_set_access) begin
                // RL1 address becomes mode word.
                mem_command <= `CMD_MODE_SET;
              end else begin
                mem_command <= `CMD_READ;
              end
            end
          end
          ST_PRE: begin
            domain_chip_select_n <= 4'h0;
            mem_command <= `CMD_PRECHARGE;
            state <= ST_NOP;
          end
          ST_NOP: state <= ST_CKE_LO;
          ST_CKE_LO: begin
            // RL12 clock enable low.
            memory_clock_enable_out <= 1'b0;
            state <= ST_AREF;
          end
          ST_AREF: begin
            // RL15 no refresh selects if the domain last decoded from read_addr has single write burst set.
            domain_chip_select_n <= cfg_word[2] ? 4'hf : 4'h0;
            mem_command <= `CMD_REFRESH;
            state <= ST_SELF;
          end
          ST_SELF: begin
            if (!in_self_refresh) begin
              domain_chip_select_n <= 4'h0;
              mem_command <= `CMD_SELF_ENTER;
              in_self_refresh <= 1'b1;
              cpu_stop_ok <= 1'b1;
            end
          end
          ST_SETTLE, ST_CKE_HI, ST_NOPS, ST_AREF2, ST_LEAVE: begin
            // Exit steps advance in the sequence below.
          end
          default: state <= ST_RUN;
        endcase
      end
      // RL13 settle wait counts controller clocks; later exit steps advance on link_rise.
      if (state == ST_SELF && wake_req) begin
        cpu_stop_ok <= 1'b0;
        count <= SETTLE_COUNT[15:0];
        state <= ST_SETTLE;
      end else if (state == ST_SETTLE) begin
        if (count <= 16'h0001) state <= ST_CKE_HI;
        else count <= count - 16'h0001;
      end else if (state == ST_CKE_HI && link_rise) begin
        memory_clock_enable_out <= 1'b1;
        count <= {12'h000, `EXIT_NOP_COUNT};
        state <= ST_NOPS;
      end else if (state == ST_NOPS && link_rise) begin
        // RL13 ten no-ops.
        if (count == 16'h0001) state <= ST_AREF2;
        count <= count - 16'h0001;
      end else if (state == ST_AREF2 && link_rise) begin
        // RL13 auto refresh; RL15 skipped for all if the last decoded domain has single write burst set.
        domain_chip_select_n <= cfg_word[2] ? 4'hf : 4'h0;
        mem_command <= `CMD_REFRESH;
        state <= ST_LEAVE;
      end else if (state == ST_LEAVE && link_rise) begin
        domain_chip_select_n <= 4'h0;
        mem_command <= `CMD_SELF_EXIT;
        in_self_refresh <= 1'b0;
        state <= ST_RUN;
      end
    end
  end
endmodule // sync_memory_mode_setup
`default_nettype wire

// ---- verif/mem_partner.sv ----
`timescale 1ns/100ps
`default_nettype none
// Memory-side clock and a counter of no-ops issued between clock-enable rise and refresh.
module mem_partner (
  output logic       link_clock,
  input  wire logic [2:0] mem_command,
  input  wire logic       memory_clock_enable_out,
  output logic [4:0] refresh_nops
);
  logic [4:0] run = 5'h0;
  logic       cke_q = 1'b0;
  initial link_clock = 1'b0;
  initial refresh_nops = 5'h0;
  always #80 link_clock = ~link_clock;
  always @(posedge link_clock) begin
    cke_q <= memory_clock_enable_out;
    if (!(memory_clock_enable_out && cke_q)) run <= 5'h0;
    else if (mem_command == 3'h0) run <= run + 5'h1;
    if (mem_command == 3'h4 && cke_q) refresh_nops <= run;
  end
endmodule // mem_partner
`default_nettype wire

// ---- verif/mode_setup_asserts.sv ----
`timescale 1ns/100ps
`default_nettype none
// Checks command words and selects against the inputs, and standby outputs against each other.
module mode_setup_asserts (
  input wire logic mclk, reset_n, init_bit, mode_set_access, load_command_access,
  input wire logic cfg_write, read_req, standby_req, read_ack, mem_data_oe,
  input wire logic memory_clock_enable_out, in_self_refresh, cpu_stop_ok,
  input wire logic [1:0] cfg_index,
  input wire logic [3:0] cfg_data, domain_chip_select_n,
  input wire logic [31:0] read_addr,
  input wire logic [15:0] flash_command, mem_data_out,
  input wire logic [12:0] mem_addr,
  input wire logic [2:0] mem_command
);
  logic [3:0] narrow;
  always @(posedge mclk)
    if (!reset_n) narrow <= 4'h0;
    else if (cfg_write) narrow[cfg_index] <= cfg_data[3];
  wire [1:0] ix = read_addr[29:28];
  wire hit = read_addr[31:30] == 2'b11 && ix != 2'b11 && !init_bit && !standby_req;
  wire [12:0] ea = narrow[ix] ? read_addr[21:9] : read_addr[22:10];
  sequence nop_hold;
    (init_bit && mode_set_access && !load_command_access && !standby_req)[*8];
  endsequence
  sequence pre_hold;
    (init_bit && !mode_set_access && !load_command_access && !standby_req)[*8];
  endsequence
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  ack_needs_req_a: assert property (read_ack |-> read_req) else $error("ack without read");
  one_select_a: assert property (mem_command == 3'h2 || mem_command == 3'h3 || mem_command == 3'h7 |->
    $onehot(~domain_chip_select_n)) else $error("not one select low");
  mode_word_a: assert property (read_ack && hit && mode_set_access && !load_command_access |=>
    mem_command == 3'h2 && mem_addr == $past(ea) && domain_chip_select_n == ~(4'h1 << $past(ix)))
    else $error("mode word wrong");
  load_word_a: assert property (read_ack && hit && load_command_access |=> mem_command == 3'h3 &&
    mem_data_oe && mem_data_out == $past(flash_command) && mem_addr == $past(ea)) else $error("load wrong");
  init_nop_a: assert property (nop_hold ##1 nop_hold |-> mem_command == 3'h0) else $error("no nop");
  init_pre_a: assert property (pre_hold ##1 pre_hold |-> mem_command == 3'h1) else $error("no pre");
  cke_self_a: assert property (cpu_stop_ok |-> !memory_clock_enable_out) else $error("cke high");
  stop_self_a: assert property (cpu_stop_ok |-> in_self_refresh) else $error("stop early");
endmodule // mode_setup_asserts
bind sync_memory_mode_setup mode_setup_asserts chk_u (.*);
`default_nettype wire

// ---- verif/sync_memory_mode_setup_bench.sv ----
`timescale 1ns/100ps
`default_nettype none
module sync_memory_mode_setup_bench;
  logic mclk = 0, reset_n = 0, init_bit = 0, mode_set_access = 0, load_command_access = 0;
  logic cfg_write = 0, boot_option_pin = 1, read_req = 0, standby_req = 0, wake_req = 0;
  logic [1:0] cfg_index = 0;
  logic [3:0] cfg_data = 0;
  logic [31:0] read_addr = 0, a;
  logic [12:0] cw, e;
  logic [15:0] flash_command = 0;
  wire logic link_clock, read_ack, mem_data_oe, memory_clock_enable_out, in_self_refresh;
  wire logic cpu_stop_ok, burst_order_field, single_write_burst;
  wire logic [12:0] mem_addr;
  wire logic [15:0] mem_data_out;
  wire logic [2:0] mem_command;
  wire logic [3:0] domain_chip_select_n;
  wire logic [1:0] device_type;
  wire logic [4:0] refresh_nops;
  int fail_count = 0, cmp_count = 0, i, n;
  sync_memory_mode_setup #(.SETTLE_COUNT(4)) dut_u (.*);
  mem_partner partner_u (.*);
  always #10 mclk = ~mclk;
  function automatic [12:0] ea(input logic [31:0] x);
    return (x[31:28] == 4'he) ? x[21:9] : x[22:10];
  endfunction
  function automatic [3:0] ecs(input logic [31:0] x);
    return (x[31:28] == 4'h0) ? 4'h7 : ~(4'h1 << x[29:28]);
  endfunction
  function automatic [2:0] dcfg(input logic [31:0] x);
    case (x[31:28])
      4'hd: return 3'h6;
      4'h0: return 3'h1;
      default: return 3'h0;
    endcase
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic finish_test;
    $display("mismatches %0d comparisons %0d", fail_count, cmp_count);
    if (fail_count == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic cfg(input logic [1:0] ix, input logic [3:0] d);
    @(negedge mclk) {cfg_index, cfg_data, cfg_write} = {ix, d, 1'b1};
    @(negedge mclk) cfg_write = 0;
  endtask
  task automatic rd(input logic [31:0] x);
    read_addr = x;
    repeat (4) @(negedge mclk);
    read_req = 1;
    n = 0;
    #1;
    while (read_ack !== 1'b1 && n < 40) begin
      @(negedge mclk);
      #1;
      n++;
    end
    if (n == 40) begin
      fail_count++;
      $display("[ERR] %0t read not acknowledged", $time);
    end
    @(negedge mclk) read_req = 0;
    @(negedge mclk);
  endtask
  task automatic wait_for(input logic want, input int lim);
    n = 0;
    while (((want ? cpu_stop_ok : in_self_refresh) !== want) && n < lim) begin
      @(negedge mclk);
      n++;
    end
    if (n == lim) begin
      fail_count++;
      $display("[ERR] %0t standby state not reached", $time);
    end
  endtask
  initial begin
    void'($urandom(32'hd6b3));
    repeat (8) @(negedge mclk);
    reset_n = 1;
    cfg(0, 4'h0);
    cfg(1, 4'h6);
    cfg(2, 4'h8);
    cfg(3, 4'h1);
    load_command_access = 1;
    flash_command = $urandom;
    rd(32'hd008_c800);
    chk({mem_data_oe, mem_command, mem_addr}, {1'b1, 3'h3, ea(32'hd008_c800)});
    chk(mem_data_out, flash_command);
    chk({single_write_burst, device_type}, 3'h6);
    load_command_access = 0;
    mode_set_access = 1;
    for (i = 0; i < 9; i++) begin
      cw = {3'h0, 1'($urandom), 2'h0, 3'h2 + 3'($urandom % 2), 1'($urandom), 3'h2};
      a = {4'hc + 4'($urandom % 3), 28'($urandom)};
      if (a[31:28] == 4'he) begin
        cw[0] = 1'b1;
        a[21:9] = cw;
      end else begin
        a[22:10] = cw;
      end
      if (i == 6) a = 32'h0001_8400;
      if (i == 7) a = 32'he000_6600;
      if (i == 8) a = 32'hc000_c800;
      rd(a);
      e = ea(a);
      chk({mem_data_oe, mem_command, mem_addr}, {1'b0, 3'h2, e});
      chk(domain_chip_select_n, ecs(a));
      chk(burst_order_field, e[3]);
      chk({single_write_burst, device_type}, dcfg(a));
    end
    init_bit = 1;
    repeat (24) @(negedge mclk);
    chk(mem_command, 3'h0);
    mode_set_access = 0;
    repeat (24) @(negedge mclk);
    chk(mem_command, 3'h1);
    init_bit = 0;
    standby_req = 1;
    wait_for(1'b1, 400);
    chk({memory_clock_enable_out, in_self_refresh}, 2'b01);
    standby_req = 0;
    wake_req = 1;
    wait_for(1'b0, 800);
    wake_req = 0;
    chk({memory_clock_enable_out, refresh_nops}, {1'b1, 5'd10});
    finish_test;
  end
  initial begin
    #400000;
    fail_count++;
    $display("[ERR] %0t watchdog expired", $time);
    finish_test;
  end
endmodule // sync_memory_mode_setup_bench
`default_nettype wire
